/* nsef_defines.vh */
// Purpose: shared constants of the serial nand status, config and ecc report block
// Assumes: byte wide serial commands, sampled on the system clock
// Notes: opcodes, register offsets, field positions and reset values
`ifndef NSEF_DEFINES_VH
`define NSEF_DEFINES_VH

// instruction opcodes
`define NSEF_OP_RESET     8'hFF
`define NSEF_OP_WREN      8'h06
`define NSEF_OP_WRDI      8'h04
`define NSEF_OP_RDSR      8'h0F
`define NSEF_OP_RDSR_ALT  8'h05
`define NSEF_OP_WRSR      8'h1F
`define NSEF_OP_WRSR_ALT  8'h01
`define NSEF_OP_PAGE_RD   8'h13
`define NSEF_OP_PROG_EXEC 8'h10
`define NSEF_OP_BLK_ERASE 8'hD8
`define NSEF_OP_READ      8'h03
`define NSEF_OP_JEDEC     8'h9F
`define NSEF_OP_EXT_RD    8'h7C
`define NSEF_OP_EXT_WR    8'h7D

// status register address groups (upper nibble)
`define NSEF_SR_PROT 4'hA
`define NSEF_SR_CFG  4'hB
`define NSEF_SR_STAT 4'hC

// extended ecc feature register offsets
`define NSEF_EXT_THRESHOLD 8'h10
`define NSEF_EXT_EXCEED    8'h20
`define NSEF_EXT_MAX       8'h30
`define NSEF_EXT_CNT_LOW   8'h40
`define NSEF_EXT_CNT_HIGH  8'h50

// config register fields and reset value
`define NSEF_CFG_ECC_EN    4
`define NSEF_CFG_READ_MODE 3
`define NSEF_CFG_HOLD_SUP  0
`define NSEF_CFG_RST       8'h18
`define NSEF_CFG_WMASK     8'h19

// status register field positions
`define NSEF_ST_BUSY   0
`define NSEF_ST_WL     1
`define NSEF_ST_EFAIL  2
`define NSEF_ST_PFAIL  3
`define NSEF_ST_ECC_LO 4

// threshold field, limits and buffer size
`define NSEF_THR_POS      4
`define NSEF_THR_RST      4'h4
`define NSEF_THR_MAX      4'h7
`define NSEF_FLIP_UNCORR  4'hF
`define NSEF_BUF_BYTES    12'h880
`define NSEF_FILL_BYTE    8'hFF

`endif

/* nsef_fifo.v */
// Purpose: byte fifo between the data buffer engine and the serial shifter
// Assumes: one clock, synchronous clear
// Notes: ready on the fill side comes from a flip-flop
module nsef_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk_i,
  input wire srst_i,
  input wire clear_i,
  // fill side
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output reg in_ready_o,
  // drain side
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_ready_i & out_valid_o;
  wire [AW:0] count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr_reg];

  // storage write
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers, fill level and registered ready
  always @(posedge clk_i) begin
    if (srst_i || clear_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      in_ready_o <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      count_reg <= count_next;
      in_ready_o <= (count_next != DEPTH[AW:0]); // full stalls the source
    end
  end
endmodule

/* nsef_ecc_sum.v */
// Purpose: summarise per-sector flip counts of a loaded page
// Assumes: four sectors, four-bit counts, all ones means uncorrected
// Notes: purely combinational, latched by the caller
`include "nsef_defines.vh"
module nsef_ecc_sum (
  // inputs
  input wire [15:0] counts_i,
  input wire [3:0] thr_i,
  // summary
  output wire [3:0] exceed_o,
  output reg [3:0] max_cnt_o,
  output reg [2:0] max_sec_o,
  output reg [1:0] status_o
);
  integer i;
  reg uncorr;
  reg over;

  // per-sector threshold compare
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sec
      assign exceed_o[g] = (counts_i[4*g+3:4*g] >= thr_i);
    end
  endgenerate

  // maximum with lowest index on ties, then cumulative status
  always @* begin
    max_cnt_o = counts_i[3:0];
    max_sec_o = 3'h0;
    uncorr = 1'b0;
    over = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (counts_i[4*i +: 4] > max_cnt_o) begin
        max_cnt_o = counts_i[4*i +: 4];
        max_sec_o = i[2:0];
      end
      if (counts_i[4*i +: 4] == `NSEF_FLIP_UNCORR) begin
        uncorr = 1'b1;
      end
      if (counts_i[4*i +: 4] > thr_i) begin
        over = 1'b1;
      end
    end
    if (uncorr) begin
      status_o = 2'h2;
    end else if (over) begin
      status_o = 2'h3;
    end else if (max_cnt_o != 4'h0) begin
      status_o = 2'h1;
    end else begin
      status_o = 2'h0;
    end
  end
endmodule

/* nsef_regs.v */
// Purpose: status, configuration and ecc report logic behind the serial pins
// Assumes: serial mode 0 link much slower than clk_i, array engine on clk_i
// Notes: the array engine does correction and streaming; this block frames
`include "nsef_defines.vh"
module nsef_regs #(
  parameter [23:0] JEDEC_ID = 24'hA55A01 // arbitrary value
) (
  // clock and reset
  input wire clk_i,
  input wire srst_i,
  // serial pins
  input wire cs_n_i,
  input wire sclk_i,
  input wire mosi_i,
  input wire hold_n_i,
  output reg so_o,
  output reg so_oe_o,
  // array engine commands
  output reg load_req_o,
  output reg prog_req_o,
  output reg erase_req_o,
  output reg [15:0] page_addr_o,
  input wire page_locked_i,
  input wire op_done_i,
  input wire op_fail_i,
  input wire [15:0] flip_counts_i,
  output reg ecc_active_o,
  // buffer read stream
  output reg rd_req_o,
  output reg [15:0] rd_col_o,
  output reg rd_seq_o,
  output reg rd_stop_o,
  input wire [7:0] buf_data_i,
  input wire buf_valid_i,
  output wire buf_ready_o
);
  localparam S_OPC = 6'h01;
  localparam S_ARG = 6'h02;
  localparam S_WDATA = 6'h04;
  localparam S_OUT = 6'h08;
  localparam S_STREAM = 6'h10;
  localparam S_IGN = 6'h20;
  localparam K_LOAD = 2'h0;
  localparam K_PROG = 2'h1;
  localparam K_ERASE = 2'h2;

  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg sclk_prev_reg;
  reg cs_prev_reg;
  reg [5:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [6:0] rx_sh_reg;
  reg [7:0] opc_reg;
  reg [15:0] arg_reg;
  reg [1:0] byte_cnt_reg;
  reg [6:0] tx_sh_reg;
  reg [1:0] out_idx_reg;
  reg out_en_reg;
  reg [11:0] remain_reg;
  reg exec_pend_reg;
  reg [7:0] cfg_reg;
  reg [3:0] thr_reg;
  reg busy_reg;
  reg boot_reg;
  reg [1:0] op_kind_reg;
  reg wl_reg;
  reg pfail_reg;
  reg efail_reg;
  reg [1:0] ecc_st_reg;
  reg [3:0] exceed_reg;
  reg [3:0] max_cnt_reg;
  reg [2:0] max_sec_reg;
  reg [15:0] counts_reg;
  reg [7:0] out_byte;

  wire cs_n = sync2_reg[0];
  wire sclk = sync2_reg[1];
  wire mosi = sync2_reg[2];
  wire hold_n = sync2_reg[3];
  wire hold_act = ~hold_n & ~cfg_reg[`NSEF_CFG_HOLD_SUP];
  wire sclk_rise = sclk & ~sclk_prev_reg & ~cs_n & ~hold_act;
  wire sclk_fall = ~sclk & sclk_prev_reg & ~cs_n & ~hold_act;
  wire cs_rise = cs_n & ~cs_prev_reg;
  wire byte_done = sclk_rise & (bit_cnt_reg == 3'h7);
  wire [7:0] rx_byte = {rx_sh_reg, mosi};
  wire load_slot = sclk_fall & (bit_cnt_reg == 3'h0);
  wire buf_end = ~rd_seq_o & (remain_reg == 12'h000);
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire fifo_pop = load_slot & (state_reg == S_STREAM) & ~buf_end & fifo_valid;
  // next stream byte, fill pattern when the engine lags
  wire [7:0] next_byte = fifo_valid ? fifo_data : `NSEF_FILL_BYTE;
  wire [7:0] stat_byte = {2'h0, ecc_st_reg, pfail_reg, efail_reg, wl_reg, busy_reg};
  wire [3:0] sum_exceed;
  wire [3:0] sum_max_cnt;
  wire [2:0] sum_max_sec;
  wire [1:0] sum_status;

  // argument bytes that follow an opcode
  function [1:0] nsef_arg_len;
    input [7:0] opc;
    begin
      case (opc)
        `NSEF_OP_RDSR, `NSEF_OP_RDSR_ALT, `NSEF_OP_WRSR, `NSEF_OP_WRSR_ALT,
        `NSEF_OP_EXT_RD, `NSEF_OP_EXT_WR, `NSEF_OP_JEDEC: nsef_arg_len = 2'h1;
        `NSEF_OP_PAGE_RD, `NSEF_OP_PROG_EXEC, `NSEF_OP_BLK_ERASE,
        `NSEF_OP_READ: nsef_arg_len = 2'h3;
        default: nsef_arg_len = 2'h0;
      endcase
    end
  endfunction

  // instructions still served while busy
  function nsef_busy_ok;
    input [7:0] opc;
    begin
      nsef_busy_ok = (opc == `NSEF_OP_RDSR) || (opc == `NSEF_OP_RDSR_ALT) ||
        (opc == `NSEF_OP_JEDEC);
    end
  endfunction

  // stream fifo between buffer engine and shifter
  nsef_fifo #(
    .WIDTH(8),
    .DEPTH(8),
    .AW(3)
  ) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .clear_i(cs_rise | rd_req_o), // drops bytes left over from a cut stream
    .in_data_i(buf_data_i),
    .in_valid_i(buf_valid_i),
    .in_ready_o(buf_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // page flip summary
  nsef_ecc_sum u_sum (
    .counts_i(flip_counts_i),
    .thr_i(thr_reg),
    .exceed_o(sum_exceed),
    .max_cnt_o(sum_max_cnt),
    .max_sec_o(sum_max_sec),
    .status_o(sum_status)
  );

  // pin synchronisers and edge history
  always @(posedge clk_i) begin
    if (srst_i) begin
      sync1_reg <= 4'h9;
      sync2_reg <= 4'h9;
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= {hold_n_i, mosi_i, sclk_i, cs_n_i};
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sclk;
      cs_prev_reg <= cs_n;
    end
  end

  // byte presented to the host in register and id reads
  always @* begin
    out_byte = 8'h00;
    case (opc_reg)
      `NSEF_OP_EXT_RD: begin
        case (arg_reg[7:0])
          `NSEF_EXT_THRESHOLD: out_byte = {thr_reg, 4'h0};
          `NSEF_EXT_EXCEED: out_byte = {4'h0, exceed_reg};
          `NSEF_EXT_MAX: out_byte = {max_cnt_reg, 1'b0, max_sec_reg};
          `NSEF_EXT_CNT_LOW: out_byte = counts_reg[7:0];
          `NSEF_EXT_CNT_HIGH: out_byte = counts_reg[15:8];
          default: out_byte = 8'h00;
        endcase
      end
      `NSEF_OP_JEDEC: begin
        case (out_idx_reg)
          2'h0: out_byte = JEDEC_ID[23:16];
          2'h1: out_byte = JEDEC_ID[15:8];
          default: out_byte = JEDEC_ID[7:0];
        endcase
      end
      default: begin
        case (arg_reg[7:4])
          `NSEF_SR_CFG: out_byte = cfg_reg;
          `NSEF_SR_STAT: out_byte = stat_byte;
          default: out_byte = 8'h00;
        endcase
      end
    endcase
  end

  // command framing, registers and array operation tracking
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= S_OPC;
      bit_cnt_reg <= 3'h0;
      rx_sh_reg <= 7'h00;
      opc_reg <= 8'h00;
      arg_reg <= 16'h0000;
      byte_cnt_reg <= 2'h0;
      tx_sh_reg <= 7'h00;
      out_idx_reg <= 2'h0;
      out_en_reg <= 1'b0;
      remain_reg <= 12'h000;
      exec_pend_reg <= 1'b0;
      cfg_reg <= `NSEF_CFG_RST;
      thr_reg <= `NSEF_THR_RST;
      busy_reg <= 1'b1;
      boot_reg <= 1'b1;
      op_kind_reg <= K_LOAD;
      wl_reg <= 1'b0;
      pfail_reg <= 1'b0;
      efail_reg <= 1'b0;
      ecc_st_reg <= 2'h0;
      exceed_reg <= 4'h0;
      max_cnt_reg <= 4'h0;
      max_sec_reg <= 3'h0;
      counts_reg <= 16'h0000;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      load_req_o <= 1'b0;
      prog_req_o <= 1'b0;
      erase_req_o <= 1'b0;
      page_addr_o <= 16'h0000;
      ecc_active_o <= 1'b0;
      rd_req_o <= 1'b0;
      rd_col_o <= 16'h0000;
      rd_seq_o <= 1'b0;
      rd_stop_o <= 1'b0;
    end else begin
      load_req_o <= 1'b0;
      prog_req_o <= 1'b0;
      erase_req_o <= 1'b0;
      rd_req_o <= 1'b0;
      rd_stop_o <= 1'b0;
      // correction only in buffer mode
      ecc_active_o <= cfg_reg[`NSEF_CFG_ECC_EN] & cfg_reg[`NSEF_CFG_READ_MODE];
      so_oe_o <= out_en_reg & ~cs_n & ~hold_act;
      // boot load of page zero
      if (boot_reg) begin
        boot_reg <= 1'b0;
        load_req_o <= 1'b1;
        page_addr_o <= 16'h0000;
        op_kind_reg <= K_LOAD;
      end
      // array operation finished
      if (op_done_i && busy_reg && !boot_reg) begin
        busy_reg <= 1'b0;
        case (op_kind_reg)
          K_LOAD: begin
            if (ecc_active_o) begin
              ecc_st_reg <= sum_status;
              exceed_reg <= sum_exceed;
              max_cnt_reg <= sum_max_cnt;
              max_sec_reg <= sum_max_sec;
              counts_reg <= flip_counts_i;
            end else begin
              ecc_st_reg <= 2'h0;
              exceed_reg <= 4'h0;
              max_cnt_reg <= 4'h0;
              max_sec_reg <= 3'h0;
              counts_reg <= 16'h0000;
            end
          end
          K_PROG: pfail_reg <= pfail_reg | op_fail_i;
          default: efail_reg <= efail_reg | op_fail_i;
        endcase
      end
      // receive side
      if (sclk_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        rx_sh_reg <= rx_byte[6:0];
      end
      if (byte_done) begin
        case (state_reg)
          S_OPC: begin
            opc_reg <= rx_byte;
            byte_cnt_reg <= 2'h0;
            if (busy_reg && !nsef_busy_ok(rx_byte)) begin
              state_reg <= S_IGN;
            end else if (nsef_arg_len(rx_byte) != 2'h0) begin
              state_reg <= S_ARG;
            end else begin
              state_reg <= S_IGN;
              case (rx_byte)
                `NSEF_OP_WREN: wl_reg <= 1'b1;
                `NSEF_OP_WRDI: wl_reg <= 1'b0;
                `NSEF_OP_RESET: begin
                  pfail_reg <= 1'b0;
                  efail_reg <= 1'b0;
                  ecc_st_reg <= 2'h0;
                end
                default: wl_reg <= wl_reg;
              endcase
            end
          end
          S_ARG: begin
            arg_reg <= {arg_reg[7:0], rx_byte};
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
            out_idx_reg <= 2'h0;
            if (byte_cnt_reg == nsef_arg_len(opc_reg) - 2'h1) begin
              case (opc_reg)
                `NSEF_OP_WRSR, `NSEF_OP_WRSR_ALT, `NSEF_OP_EXT_WR: state_reg <= S_WDATA;
                `NSEF_OP_PAGE_RD, `NSEF_OP_PROG_EXEC, `NSEF_OP_BLK_ERASE: begin
                  page_addr_o <= {arg_reg[7:0], rx_byte};
                  exec_pend_reg <= 1'b1;
                  state_reg <= S_IGN;
                end
                `NSEF_OP_READ: begin
                  state_reg <= S_STREAM;
                  rd_req_o <= 1'b1;
                  rd_seq_o <= ~cfg_reg[`NSEF_CFG_READ_MODE];
                  if (cfg_reg[`NSEF_CFG_READ_MODE]) begin
                    rd_col_o <= arg_reg;
                    remain_reg <= (arg_reg < {4'h0, `NSEF_BUF_BYTES}) ?
                      (`NSEF_BUF_BYTES - arg_reg[11:0]) : 12'h000;
                  end else begin
                    rd_col_o <= 16'h0000;
                    remain_reg <= 12'h000;
                  end
                end
                default: state_reg <= S_OUT;
              endcase
            end
          end
          S_WDATA: begin
            state_reg <= S_IGN;
            if (opc_reg == `NSEF_OP_EXT_WR) begin
              if (arg_reg[7:0] == `NSEF_EXT_THRESHOLD &&
                  rx_byte[7:4] != 4'h0 && rx_byte[7:4] <= `NSEF_THR_MAX) begin
                thr_reg <= rx_byte[7:4];
              end
            end else if (arg_reg[7:4] == `NSEF_SR_CFG) begin
              cfg_reg <= rx_byte & `NSEF_CFG_WMASK;
            end
          end
          S_OUT, S_STREAM, S_IGN: state_reg <= state_reg;
          default: state_reg <= S_IGN;
        endcase
      end
      // transmit side, one bit per falling edge
      if (sclk_fall && (state_reg == S_OUT || state_reg == S_STREAM)) begin
        if (!load_slot) begin
          so_o <= tx_sh_reg[6];
          tx_sh_reg <= {tx_sh_reg[5:0], 1'b0};
        end else if (state_reg == S_OUT) begin
          so_o <= out_byte[7];
          tx_sh_reg <= out_byte[6:0];
          out_en_reg <= 1'b1;
          if (out_idx_reg != 2'h3) begin
            out_idx_reg <= out_idx_reg + 2'h1;
          end
        end else if (buf_end) begin
          out_en_reg <= 1'b0;
        end else begin
          so_o <= next_byte[7];
          tx_sh_reg <= next_byte[6:0];
          out_en_reg <= 1'b1;
          if (!rd_seq_o) begin
            remain_reg <= remain_reg - 12'h001;
          end
        end
      end
      // end of frame: execute array commands, stop streams
      if (cs_rise) begin
        state_reg <= S_OPC;
        bit_cnt_reg <= 3'h0;
        out_en_reg <= 1'b0;
        exec_pend_reg <= 1'b0;
        if (state_reg == S_STREAM) begin
          rd_stop_o <= 1'b1;
        end
        if (exec_pend_reg) begin
          case (opc_reg)
            `NSEF_OP_PAGE_RD: begin
              wl_reg <= 1'b0;
              ecc_st_reg <= 2'h0;
              busy_reg <= 1'b1;
              op_kind_reg <= K_LOAD;
              load_req_o <= 1'b1;
            end
            `NSEF_OP_PROG_EXEC: begin
              wl_reg <= 1'b0;
              if (page_locked_i || !wl_reg) begin
                pfail_reg <= 1'b1;
              end else begin
                pfail_reg <= 1'b0;
                busy_reg <= 1'b1;
                op_kind_reg <= K_PROG;
                prog_req_o <= 1'b1;
              end
            end
            default: begin
              wl_reg <= 1'b0;
              if (page_locked_i || !wl_reg) begin
                efail_reg <= 1'b1;
              end else begin
                efail_reg <= 1'b0;
                busy_reg <= 1'b1;
                op_kind_reg <= K_ERASE;
                erase_req_o <= 1'b1;
              end
            end
          endcase
        end
      end
    end
  end
endmodule

/* nsef_dummy_unused_guard.v */
// Purpose: spare source slot of the status block
// Assumes: nothing
// Notes: holds no logic; the block lives in nsef_regs.v and its two helpers

/* nsef_regs_monitor.sv */
// Purpose: port checker of nsef_regs
// Assumes: one clock, synchronous reset
// Notes: bound after the module
module nsef_regs_monitor (
  // clock, reset, pins
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cs_n_i,
  input wire logic so_oe_o,
  // engine side
  input wire logic load_req_o,
  input wire logic prog_req_o,
  input wire logic erase_req_o,
  input wire logic [15:0] page_addr_o,
  input wire logic ecc_active_o,
  input wire logic rd_req_o,
  input wire logic [15:0] rd_col_o,
  input wire logic rd_seq_o,
  input wire logic rd_stop_o,
  input wire logic buf_ready_o
);
  // any array request
  wire any_req = load_req_o | prog_req_o | erase_req_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // assertions
  req_gap_a: assert property (any_req |=> !any_req [*8]) else $error("req gap");
  one_req_a: assert property ($onehot0({load_req_o, prog_req_o, erase_req_o}))
    else $error("two reqs");
  boot_load_a: assert property ($fell(srst_i) |->
    ##[0:2] (load_req_o && page_addr_o == 16'h0000)) else $error("no boot load");
  rst_idle_a: assert property (disable iff (1'b0) srst_i |=>
    !so_oe_o && !any_req && buf_ready_o) else $error("reset state");
  seq_col_a: assert property (rd_req_o && rd_seq_o |-> rd_col_o == 16'h0000)
    else $error("seq column");
  seq_ecc_a: assert property (rd_req_o && rd_seq_o |-> !ecc_active_o)
    else $error("seq ecc");
  cs_idle_a: assert property (cs_n_i [*5] |-> !so_oe_o) else $error("oe idle");
  rd_frame_a: assert property (cs_n_i [*5] |-> !rd_req_o) else $error("rd outside");
  stop_idle_a: assert property (rd_stop_o |=> !so_oe_o) else $error("oe after stop");
  // main scenarios
  cover property (load_req_o);
  cover property (rd_req_o && rd_seq_o);
  cover property ($rose(so_oe_o));
endmodule

bind nsef_regs nsef_regs_monitor mon (.clk_i, .srst_i, .cs_n_i, .so_oe_o, .load_req_o,
  .prog_req_o, .erase_req_o, .page_addr_o, .ecc_active_o, .rd_req_o, .rd_col_o, .rd_seq_o,
  .rd_stop_o, .buf_ready_o);

/* nsef_engine_model.sv */
// Purpose: array engine stand-in for nsef_regs
// Assumes: single-cycle request pulses
// Notes: answers after DLY cycles
module nsef_engine_model #(
  parameter int DLY = 400
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // array operations
  input wire logic req_i,
  input wire logic [15:0] cnt_i,
  input wire logic fail_i,
  output logic op_done_o,
  output logic op_fail_o,
  output logic [15:0] counts_o,
  // byte stream
  input wire logic rd_req_i,
  input wire logic [15:0] rd_col_i,
  input wire logic rd_stop_i,
  input wire logic ready_i,
  output logic [7:0] data_o,
  output logic valid_o
);
  int left;
  logic [15:0] ptr;
  // operation timer
  always @(posedge clk_i) begin
    op_done_o <= (left == 1);
    if (srst_i) left <= 0;
    else if (req_i) left <= DLY;
    else if (left != 0) left <= left - 1;
  end
  // counts and fail only valid with done
  assign op_fail_o = op_done_o & fail_i;
  assign counts_o = op_done_o ? cnt_i : ~cnt_i;
  // stream from the start column until stopped
  always @(posedge clk_i) begin
    if (srst_i || rd_stop_i) valid_o <= 1'b0;
    else if (rd_req_i) valid_o <= 1'b1;
    if (rd_req_i) ptr <= rd_col_i;
    else if (valid_o && ready_i) ptr <= ptr + 16'h0001;
  end
  assign data_o = valid_o ? ptr[7:0] : ~ptr[7:0];
endmodule

/* nsef_regs_tb.sv */
// Purpose: self-checking bench of nsef_regs
// Assumes: mode 0 serial host, sclk 800 ns
// Notes: engine model answers after 400 cycles
module nsef_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, so_o, so_oe_o, load_req_o, prog_req_o, erase_req_o, op_done_i, op_fail_i;
  logic ecc_active_o, rd_req_o, rd_seq_o, rd_stop_o, buf_valid_i, buf_ready_o, oe;
  logic srst_i = 1'b1, cs_n_i = 1'b1, sclk_i = 1'b0, mosi_i = 1'b0, hold_n_i = 1'b1;
  logic page_locked_i = 1'b0, fl = 1'b0;
  logic [15:0] page_addr_o, flip_counts_i, rd_col_o, cnt = 16'h0000;
  logic [7:0] buf_data_i, rd;
  logic [7:0] rb [0:3];
  int fail_count = 0, check_count = 0, cyc = 0;
  localparam logic [23:0] ID = 24'h3C1E05; // arbitrary value
  nsef_regs #(.JEDEC_ID(ID)) dut (.clk_i, .srst_i, .cs_n_i, .sclk_i, .mosi_i, .hold_n_i, .so_o,
    .so_oe_o,
    .load_req_o, .prog_req_o, .erase_req_o, .page_addr_o, .page_locked_i, .op_done_i,
    .op_fail_i, .flip_counts_i, .ecc_active_o, .rd_req_o, .rd_col_o, .rd_seq_o, .rd_stop_o,
    .buf_data_i, .buf_valid_i, .buf_ready_o);
  nsef_engine_model eng (.clk_i, .srst_i, .req_i(load_req_o | prog_req_o | erase_req_o),
    .cnt_i(cnt), .fail_i(fl), .op_done_o(op_done_i), .op_fail_o(op_fail_i),
    .counts_o(flip_counts_i), .rd_req_i(rd_req_o), .rd_col_i(rd_col_o), .rd_stop_i(rd_stop_o),
    .ready_i(buf_ready_o), .data_o(buf_data_i), .valid_o(buf_valid_i));
  // clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // cycle ceiling against hangs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) fail_count++;
    if (cyc == 30000) finish_test();
  end
  // one frame: n command bytes from the top of b, then nr read bytes
  task fr(input logic [31:0] b, input int n, input int nr);
    logic [7:0] q;
    cs_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int k = 0; k < n + nr; k++) begin
      for (int i = 7; i >= 0; i--) begin
        sclk_i = 1'b0;
        mosi_i = k < n ? b[24 - 8 * k + i] : 1'b0;
        repeat (4) @(negedge clk_i);
        sclk_i = 1'b1;
        repeat (4) @(negedge clk_i);
        q[i] = so_o;
      end
      rb[(k - n) & 3] = q;
    end
    rd = q;
    oe = so_oe_o;
    sclk_i = 1'b0;
    repeat (4) @(negedge clk_i);
    cs_n_i = 1'b1;
    repeat (12) @(negedge clk_i);
  endtask
  // byte compare
  task chk(input logic [7:0] a, input logic [7:0] e);
    check_count++;
    if (a !== e) fail_count++;
    if (a !== e) $display("BAD t=%0t got=%h exp=%h", $time, a, e);
  endtask
  // register read and compare
  task rg(input logic [7:0] op, input logic [7:0] a, input logic [7:0] e);
    fr({op, a, 16'h0000}, 2, 1);
    chk(rd, e);
  endtask
  // poll busy, bounded
  task wt;
    for (int j = 0; j < 20; j++) begin
      fr(32'h0FC00000, 2, 1);
      if (rd[0] === 1'b0) break;
    end
  endtask
  // page load with given flip counts
  task pr(input logic [15:0] c, input logic [7:0] e);
    cnt = c;
    fr(32'h13000001, 4, 0);
    wt();
    chk(rd, e);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(negedge clk_i);
    srst_i = 1'b0;
    fr(32'h06000000, 1, 0);
    rg(8'h0F, 8'hC0, 8'h01);
    fr(32'h9F000000, 2, 3);
    chk(rb[0], ID[23:16]);
    chk(rb[1], ID[15:8]);
    chk(rb[2], ID[7:0]);
    wt();
    chk(rd, 8'h00);
    fr(32'h06000000, 1, 0);
    rg(8'h0F, 8'hC0, 8'h02);
    rg(8'h0F, 8'hB0, 8'h18);
    rg(8'h7C, 8'h10, 8'h40);
    fr(32'h7D100000, 3, 0);
    fr(32'h7D109000, 3, 0);
    rg(8'h7C, 8'h10, 8'h40);
    fr(32'h7D103000, 3, 0);
    rg(8'h7C, 8'h10, 8'h30);
    pr(16'h0352, 8'h30);
    rg(8'h7C, 8'h20, 8'h06);
    rg(8'h7C, 8'h30, 8'h51);
    rg(8'h7C, 8'h40, 8'h52);
    rg(8'h7C, 8'h50, 8'h03);
    pr(16'h00F1, 8'h20);
    fr(32'hFF000000, 1, 0);
    rg(8'h0F, 8'hC0, 8'h00);
    rg(8'h0F, 8'hB0, 8'h18);
    page_locked_i = 1'b1;
    fr(32'h06000000, 1, 0);
    fr(32'h10000005, 4, 0);
    fr(32'h04000000, 1, 0);
    rg(8'h0F, 8'hC0, 8'h08);
    page_locked_i = 1'b0;
    fl = 1'b1;
    fr(32'h06000000, 1, 0);
    fr(32'hD8000040, 4, 0);
    wt();
    chk(rd, 8'h0C);
    fl = 1'b0;
    fr(32'h06000000, 1, 0);
    fr(32'h10000005, 4, 0);
    wt();
    chk(rd, 8'h04);
    chk(page_addr_o[7:0], 8'h05);
    fr(32'h03087E00, 4, 3);
    chk(rb[0], 8'h7E);
    chk(rb[1], 8'h7F);
    chk({7'h00, oe}, 8'h00);
    chk(rd_col_o[7:0], 8'h7E);
    fr(32'h1FB00100, 3, 0);
    chk({7'h00, ecc_active_o}, 8'h00);
    fr(32'h0FC00000, 2, 1);
    chk(rd & 8'hCF, 8'h04);
    hold_n_i = 1'b0;
    fr(32'h03012300, 4, 2);
    chk(rb[0], 8'h00);
    chk(rb[1], 8'h01);
    chk(rd_col_o[7:0], 8'h00);
    chk({7'h00, rd_seq_o}, 8'h01);
    finish_test();
  end
endmodule
